/* tlic_pkg.sv */
// package for the two-level interrupt controller: source order, vectors, carriers
`default_nettype none
package tlic_pkg;
    // number of request lines after merging shared-vector flags
    localparam int unsigned NUM_SRC = 11;
    // source indices in polling order, index 0 polled first
    localparam int unsigned SRC_PSM = 0;
    localparam int unsigned SRC_WDG = 1;
    localparam int unsigned SRC_EX0 = 2;
    localparam int unsigned SRC_CNV = 3;
    localparam int unsigned SRC_TM0 = 4;
    localparam int unsigned SRC_EX1 = 5;
    localparam int unsigned SRC_TM1 = 6;
    localparam int unsigned SRC_SPI = 7;
    localparam int unsigned SRC_URT = 8;
    localparam int unsigned SRC_TM2 = 9;
    localparam int unsigned SRC_TIC = 10;
    // vector addresses indexed by polling position
    localparam logic [15:0] VEC_PSM = 16'h0043;
    localparam logic [15:0] VEC_WDG = 16'h005b;
    localparam logic [15:0] VEC_EX0 = 16'h0003;
    localparam logic [15:0] VEC_CNV = 16'h0033;
    localparam logic [15:0] VEC_TM0 = 16'h000b;
    localparam logic [15:0] VEC_EX1 = 16'h0013;
    localparam logic [15:0] VEC_TM1 = 16'h001b;
    localparam logic [15:0] VEC_SPI = 16'h003b;
    localparam logic [15:0] VEC_URT = 16'h0023;
    localparam logic [15:0] VEC_TM2 = 16'h002b;
    localparam logic [15:0] VEC_TIC = 16'h0053;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [3:0] WDT_TIMEOUT_ZERO = 4'h0;
    localparam logic [3:0] SRC_IDX_NONE = 4'hf;
    // raw peripheral flags as seen by the controller
    typedef struct packed {
        logic supply_monitor_request;
        logic watchdog_timeout_flag;
        logic ext0_request_flag;
        logic [1:0] converter_ready_flags;
        logic timer0_overflow;
        logic ext1_request_flag;
        logic timer1_overflow;
        logic serial_peripheral_request;
        logic [1:0] uart_rx_tx_flags;
        logic [1:0] timer2_flags;
        logic interval_counter_request;
    } tlic_flags_s;
    // vector handed to the core on acceptance
    typedef struct packed {
        logic push_pc;
        logic [15:0] push_value;
        logic [15:0] vector;
        logic [3:0] src_idx;
        logic high_level;
    } tlic_accept_s;
    typedef enum logic [1:0] {
        TLIC_IDLE_ONE,
        TLIC_LOW_ONE,
        TLIC_HIGH_ONE,
        TLIC_HIGH_OVER_LOW
    } tlic_svc_e;
endpackage : tlic_pkg
`default_nettype wire

/* tlic_poll.sv */
// fixed-order polling picker for one priority level
`timescale 1ns/1ps
`default_nettype none
module tlic_poll (
    input wire logic [10:0] req, // requests of one level, bit 0 polled first
    output logic any, // at least one request present
    output logic [3:0] idx // index of the first request in polling order
);
    // lowest set index wins; scan from last so earlier sources overwrite
    always_comb begin
        any = 1'b0;
        idx = tlic_pkg::SRC_IDX_NONE;
        for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = 4'(i);
            end
        end
    end
endmodule // tlic_poll
`default_nettype wire

/* tlic_ctrl.sv */
// two-level prioritised interrupt controller with polling order and vectoring
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module tlic_ctrl (
    input wire logic clk, // core clock, 200 MHz
    input wire logic srst, // synchronous reset, active high
    input wire tlic_pkg::tlic_flags_s flags, // raw peripheral flags
    input wire logic [10:0] src_enable, // per-source enables, polling order
    input wire logic [10:0] src_priority, // per-source priority, 1 = high
    input wire logic global_irq_gate, // global enable
    input wire logic watchdog_irq_select, // 1 = watchdog interrupts, not resets
    input wire logic [3:0] watchdog_timeout_sel, // watchdog timeout setting
    input wire logic [15:0] core_pc, // program counter of the core
    input wire logic accept_ready, // core can take an interrupt this cycle
    input wire logic reti_exec, // core executes a return-from-interrupt
    output logic irq_take, // one-cycle pulse: push pc, load vector
    output logic [15:0] irq_push_pc, // pc to push onto the stack
    output logic [15:0] irq_vector, // vector to load into pc
    output logic [3:0] irq_src_idx, // polling index of the accepted source
    output logic irq_high_level, // accepted source was high level
    output logic watchdog_reset_req, // watchdog timeout when not interrupting
    output logic [1:0] in_service // bit1 high in service, bit0 low in service
);
    // -----------------------------------------------------------------------
    // request forming
    // -----------------------------------------------------------------------
    // a net, since each bit has its own continuous assignment
    wire [10:0] raw_req;
    logic [10:0] gated_req;
    logic [10:0] eff_high;
    logic [10:0] high_req;
    logic [10:0] low_req;
    logic wdg_armed;
    logic wdg_irq;
    // shared-vector flags merge into one line each
    assign raw_req[tlic_pkg::SRC_PSM] = flags.supply_monitor_request;
    assign raw_req[tlic_pkg::SRC_WDG] = 1'b0; // handled separately below
    assign raw_req[tlic_pkg::SRC_EX0] = flags.ext0_request_flag;
    assign raw_req[tlic_pkg::SRC_CNV] = |flags.converter_ready_flags;
    assign raw_req[tlic_pkg::SRC_TM0] = flags.timer0_overflow;
    assign raw_req[tlic_pkg::SRC_EX1] = flags.ext1_request_flag;
    assign raw_req[tlic_pkg::SRC_TM1] = flags.timer1_overflow;
    assign raw_req[tlic_pkg::SRC_SPI] = flags.serial_peripheral_request;
    assign raw_req[tlic_pkg::SRC_URT] = |flags.uart_rx_tx_flags;
    assign raw_req[tlic_pkg::SRC_TM2] = |flags.timer2_flags;
    assign raw_req[tlic_pkg::SRC_TIC] = flags.interval_counter_request;
    // watchdog bypasses the global gate and the enable bits
    assign wdg_armed = watchdog_timeout_sel != tlic_pkg::WDT_TIMEOUT_ZERO;
    assign wdg_irq = flags.watchdog_timeout_flag & watchdog_irq_select & wdg_armed;
    // global gate and per-source enables; watchdog line ored in ungated
    assign gated_req = (raw_req & src_enable & {11{global_irq_gate}})
                     | (11'(wdg_irq) << tlic_pkg::SRC_WDG);
    // watchdog forced high whatever its priority bit says
    assign eff_high = src_priority | (11'h001 << tlic_pkg::SRC_WDG);
    assign high_req = gated_req & eff_high;
    assign low_req = gated_req & ~eff_high;
    // -----------------------------------------------------------------------
    // polling and arbitration
    // -----------------------------------------------------------------------
    logic high_any;
    logic low_any;
    logic [3:0] high_idx;
    logic [3:0] low_idx;
    tlic_poll u_poll_high (
        .req(high_req),
        .any(high_any),
        .idx(high_idx)
    );
    tlic_poll u_poll_low (
        .req(low_req),
        .any(low_any),
        .idx(low_idx)
    );
    logic high_busy_reg;
    logic low_busy_reg;
    logic high_ok;
    logic low_ok;
    logic take;
    logic [3:0] pick_idx;
    logic [15:0] pick_vec;
    // high blocked only by a high routine; low blocked by any routine
    assign high_ok = high_any & ~high_busy_reg;
    assign low_ok = low_any & ~high_busy_reg & ~low_busy_reg;
    assign take = accept_ready & ~reti_exec & (high_ok | low_ok);
    // high wins over low when both are ready in one cycle
    assign pick_idx = high_ok ? high_idx : low_idx;
    // vector lookup by polling index
    always_comb begin
        case (pick_idx)
            4'(tlic_pkg::SRC_PSM): pick_vec = tlic_pkg::VEC_PSM;
            4'(tlic_pkg::SRC_WDG): pick_vec = tlic_pkg::VEC_WDG;
            4'(tlic_pkg::SRC_EX0): pick_vec = tlic_pkg::VEC_EX0;
            4'(tlic_pkg::SRC_CNV): pick_vec = tlic_pkg::VEC_CNV;
            4'(tlic_pkg::SRC_TM0): pick_vec = tlic_pkg::VEC_TM0;
            4'(tlic_pkg::SRC_EX1): pick_vec = tlic_pkg::VEC_EX1;
            4'(tlic_pkg::SRC_TM1): pick_vec = tlic_pkg::VEC_TM1;
            4'(tlic_pkg::SRC_SPI): pick_vec = tlic_pkg::VEC_SPI;
            4'(tlic_pkg::SRC_URT): pick_vec = tlic_pkg::VEC_URT;
            4'(tlic_pkg::SRC_TM2): pick_vec = tlic_pkg::VEC_TM2;
            4'(tlic_pkg::SRC_TIC): pick_vec = tlic_pkg::VEC_TIC;
            default: pick_vec = tlic_pkg::PC_RESET;
        endcase
    end
    // -----------------------------------------------------------------------
    // in-service tracking
    // -----------------------------------------------------------------------
    tlic_pkg::tlic_svc_e svc_reg;
    tlic_pkg::tlic_svc_e svc_next;
    // reti closes the innermost level; take is suppressed in that cycle so
    // the pop and a new push never collide in the state
    always_comb begin
        svc_next = svc_reg;
        case (svc_reg)
            tlic_pkg::TLIC_IDLE_ONE: begin
                if (take) begin
                    svc_next = high_ok ? tlic_pkg::TLIC_HIGH_ONE : tlic_pkg::TLIC_LOW_ONE;
                end
            end
            tlic_pkg::TLIC_LOW_ONE: begin
                if (reti_exec) begin
                    svc_next = tlic_pkg::TLIC_IDLE_ONE;
                end else if (take) begin
                    svc_next = tlic_pkg::TLIC_HIGH_OVER_LOW;
                end
            end
            tlic_pkg::TLIC_HIGH_ONE: begin
                if (reti_exec) begin
                    svc_next = tlic_pkg::TLIC_IDLE_ONE;
                end
            end
            tlic_pkg::TLIC_HIGH_OVER_LOW: begin
                if (reti_exec) begin
                    svc_next = tlic_pkg::TLIC_LOW_ONE;
                end
            end
            default: svc_next = tlic_pkg::TLIC_IDLE_ONE;
        endcase
    end
    assign high_busy_reg = (svc_reg == tlic_pkg::TLIC_HIGH_ONE) | (svc_reg == tlic_pkg::TLIC_HIGH_OVER_LOW);
    assign low_busy_reg = (svc_reg == tlic_pkg::TLIC_LOW_ONE) | (svc_reg == tlic_pkg::TLIC_HIGH_OVER_LOW);
    // registered copy of the busy decode so the in_service port comes from a flop
    logic [1:0] in_svc_reg;
    logic [1:0] in_svc_next;
    assign in_svc_next[1] = (svc_next == tlic_pkg::TLIC_HIGH_ONE) | (svc_next == tlic_pkg::TLIC_HIGH_OVER_LOW);
    assign in_svc_next[0] = (svc_next == tlic_pkg::TLIC_LOW_ONE) | (svc_next == tlic_pkg::TLIC_HIGH_OVER_LOW);
    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            svc_reg <= tlic_pkg::TLIC_IDLE_ONE;
            in_svc_reg <= 2'b00;
        end else begin
            svc_reg <= svc_next;
            in_svc_reg <= in_svc_next;
        end
    end
    // -----------------------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------------------
    tlic_pkg::tlic_accept_s acc_reg;
    // a net, since each field has its own continuous assignment
    wire tlic_pkg::tlic_accept_s acc_next;
    assign acc_next.push_pc = take;
    assign acc_next.push_value = core_pc;
    assign acc_next.vector = pick_vec;
    assign acc_next.src_idx = pick_idx;
    assign acc_next.high_level = high_ok;
    // vector fields held from the last acceptance, pulse cleared each cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_reg <= '0;
        end else if (take) begin
            acc_reg <= acc_next;
        end else begin
            acc_reg.push_pc <= 1'b0;
        end
    end
    logic wdg_rst_reg;
    // a timeout without interrupt mode asks the reset logic to act
    always_ff @(posedge clk) begin
        if (srst) begin
            wdg_rst_reg <= 1'b0;
        end else begin
            wdg_rst_reg <= flags.watchdog_timeout_flag & ~watchdog_irq_select;
        end
    end
    assign irq_take = acc_reg.push_pc;
    assign irq_push_pc = acc_reg.push_value;
    assign irq_vector = acc_reg.vector;
    assign irq_src_idx = acc_reg.src_idx;
    assign irq_high_level = acc_reg.high_level;
    assign watchdog_reset_req = wdg_rst_reg;
    assign in_service = in_svc_reg;
    // -----------------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------------
    a_same_level_block: assert property (@(posedge clk) disable iff (srst)
        irq_take && irq_high_level |-> $past(!high_busy_reg))
        else $error("high request taken during high service");
    a_low_needs_idle: assert property (@(posedge clk) disable iff (srst)
        irq_take && !irq_high_level |-> $past(svc_reg == tlic_pkg::TLIC_IDLE_ONE))
        else $error("low request taken while a routine runs");
    a_high_first: assert property (@(posedge clk) disable iff (srst)
        take && high_ok && low_ok |=> irq_take && irq_high_level)
        else $error("low taken ahead of high");
    a_preempt_low: assert property (@(posedge clk) disable iff (srst)
        svc_reg == tlic_pkg::TLIC_LOW_ONE && high_any && accept_ready && !reti_exec
        |=> irq_take && irq_high_level && svc_reg == tlic_pkg::TLIC_HIGH_OVER_LOW)
        else $error("high request failed to preempt low routine");
    a_wdg_vector: assert property (@(posedge clk) disable iff (srst)
        irq_take && irq_src_idx == 4'(tlic_pkg::SRC_WDG) |-> irq_vector == tlic_pkg::VEC_WDG && irq_high_level)
        else $error("watchdog vector or level wrong");
    a_wdg_ungated: assert property (@(posedge clk) disable iff (srst)
        flags.watchdog_timeout_flag && watchdog_irq_select && wdg_armed && !global_irq_gate
        && svc_reg == tlic_pkg::TLIC_IDLE_ONE && accept_ready && !reti_exec
        |=> irq_take && irq_src_idx == 4'(tlic_pkg::SRC_WDG))
        else $error("watchdog masked by global gate");
    a_wdg_zero_quiet: assert property (@(posedge clk) disable iff (srst)
        watchdog_timeout_sel == tlic_pkg::WDT_TIMEOUT_ZERO |=> !(irq_take && irq_src_idx == 4'(tlic_pkg::SRC_WDG)))
        else $error("watchdog interrupt with zero timeout");
    a_gate_blocks: assert property (@(posedge clk) disable iff (srst)
        !global_irq_gate |=> !irq_take || irq_src_idx == 4'(tlic_pkg::SRC_WDG))
        else $error("source taken with global gate closed");
    a_push_pc: assert property (@(posedge clk) disable iff (srst)
        take |=> irq_take && irq_push_pc == $past(core_pc))
        else $error("pushed pc does not match core pc");
    a_reti_pop: assert property (@(posedge clk) disable iff (srst)
        reti_exec && svc_reg == tlic_pkg::TLIC_HIGH_OVER_LOW |=> svc_reg == tlic_pkg::TLIC_LOW_ONE)
        else $error("return did not restore low service");
    a_poll_order: assert property (@(posedge clk) disable iff (srst)
        take && !high_ok && low_req[tlic_pkg::SRC_PSM] |=> irq_src_idx == 4'(tlic_pkg::SRC_PSM))
        else $error("supply monitor not first among low requests");
endmodule // tlic_ctrl
`default_nettype wire

/* tlic_core_model.sv */
// behavioural model of the core side: running program counter and acceptance window
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
    input wire logic clk, // core clock
    input wire logic srst, // synchronous reset, active high
    input wire logic slow, // 1 = acceptance opens only one cycle in four
    input wire logic irq_take, // acceptance pulse from the controller
    input wire logic [15:0] irq_vector, // vector to jump to
    output logic [15:0] core_pc, // running program counter
    output logic accept_ready // core can take an interrupt this cycle
);
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    // ---------------------------------------------------------------
    // program counter
    // ---------------------------------------------------------------
    // jump lands one cycle after the take, so the pushed value is the pre-take pc
    assign pc_next = irq_take ? irq_vector : pc_reg + 16'h0001;
    always_ff @(posedge clk) begin
        if (srst) begin
            pc_reg <= tlic_pkg::PC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end
    assign core_pc = pc_reg;
    // slow mode mimics a core busy inside multi-cycle instructions
    assign accept_ready = !slow || (pc_reg[1:0] == 2'b00);
endmodule // tlic_core_model
`default_nettype wire

/* tlic_ctrl_tb.sv */
// self-checking testbench for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tlic_ctrl_tb;
    logic clk, srst, gate, wsel, reti, slow, irq_take, irq_high_level, watchdog_reset_req, accept_ready;
    tlic_pkg::tlic_flags_s flags;
    logic [10:0] en, pri;
    logic [3:0] wto, irq_src_idx;
    logic [15:0] core_pc, irq_push_pc, irq_vector;
    logic [1:0] in_service;
    int n_fail = 0;
    int checked = 0;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    tlic_ctrl DUT (.clk(clk), .srst(srst), .flags(flags), .src_enable(en), .src_priority(pri),
        .global_irq_gate(gate), .watchdog_irq_select(wsel), .watchdog_timeout_sel(wto), .core_pc(core_pc),
        .accept_ready(accept_ready), .reti_exec(reti), .irq_take(irq_take), .irq_push_pc(irq_push_pc),
        .irq_vector(irq_vector), .irq_src_idx(irq_src_idx), .irq_high_level(irq_high_level),
        .watchdog_reset_req(watchdog_reset_req), .in_service(in_service));
    tlic_core_model core (.clk(clk), .srst(srst), .slow(slow), .irq_take(irq_take), .irq_vector(irq_vector),
        .core_pc(core_pc), .accept_ready(accept_ready));
    // ---------------------------------------------------------------
    // flag masks and vectors by polling index
    // ---------------------------------------------------------------
    // paired sources use one bit of their pair only, the other bit is covered elsewhere
    function automatic logic [13:0] msk(input int i);
        case (i)
            0: return 14'h2000;
            1: return 14'h1000;
            2: return 14'h0800;
            3: return 14'h0200;
            4: return 14'h0100;
            5: return 14'h0080;
            6: return 14'h0040;
            7: return 14'h0020;
            8: return 14'h0010;
            9: return 14'h0002;
            default: return 14'h0001;
        endcase
    endfunction
    function automatic logic [15:0] vec(input int i);
        case (i)
            0: return tlic_pkg::VEC_PSM;
            1: return tlic_pkg::VEC_WDG;
            2: return tlic_pkg::VEC_EX0;
            3: return tlic_pkg::VEC_CNV;
            4: return tlic_pkg::VEC_TM0;
            5: return tlic_pkg::VEC_EX1;
            6: return tlic_pkg::VEC_TM1;
            7: return tlic_pkg::VEC_SPI;
            8: return tlic_pkg::VEC_URT;
            9: return tlic_pkg::VEC_TM2;
            default: return tlic_pkg::VEC_TIC;
        endcase
    endfunction
    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic set(input logic [13:0] m);
        @(posedge clk);
        flags <= tlic_pkg::tlic_flags_s'(flags | m);
    endtask
    task automatic clr(input logic [13:0] m);
        @(posedge clk);
        flags <= tlic_pkg::tlic_flags_s'(flags & ~m);
    endtask
    // bounded wait for the take pulse, then everything it carries
    task automatic take(input int i, input logic hi, input logic [1:0] svc);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < 40 && !seen; k++) begin
            @(posedge clk);
            #1;
            seen = (irq_take === 1'b1);
        end
        if (!seen) begin
            n_fail++;
            $display("wrong value at %0t: no take", $time);
            close_out();
        end else begin
            chk(16'(irq_src_idx), 16'(i), "source index");
            chk(irq_vector, vec(i), "vector");
            chk(16'(irq_high_level), 16'(hi), "level");
            chk(irq_push_pc, core_pc - 16'h0001, "pushed pc");
            chk(16'(in_service), 16'(svc), "in service after take");
        end
    endtask
    task automatic none(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk(16'(irq_take), 16'h0000, "unexpected take");
        end
    endtask
    task automatic ret(input logic [1:0] svc);
        @(posedge clk);
        reti <= 1'b1;
        @(posedge clk);
        reti <= 1'b0;
        #1;
        chk(16'(in_service), 16'(svc), "in service after return");
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        srst = 1'b1;
        flags = '0;
        en = '0;
        pri = '0;
        gate = 1'b0;
        wsel = 1'b1;
        wto = 4'h3;
        reti = 1'b0;
        slow = 1'b0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk(16'(in_service) | 16'(irq_take), 16'h0000, "idle after reset");
        @(posedge clk);
        gate <= 1'b1;
        en <= 11'h7ff;
        // every source alone, all but the watchdog at low priority, core alternately slow
        for (int i = 0; i < 11; i++) begin
            slow = i[0];
            set(msk(i));
            take(i, i == 1, (i == 1) ? 2'b10 : 2'b01);
            clr(msk(i));
            ret(2'b00);
        end
        slow = 1'b0;
        // all low sources at once, other pair bits used: served in polling order
        set(14'h2ded);
        for (int i = 0; i < 11; i++) begin
            if (i != 1) begin
                take(i, 1'b0, 2'b01);
                if (i != 10) none(4);
                clr(14'h3fff & (i == 3 ? 14'h0600 : i == 8 ? 14'h0018 : i == 9 ? 14'h0006 : msk(i)));
                ret(2'b00);
            end
        end
        // mixed levels: high first, then preemption of a low routine
        @(posedge clk);
        pri <= 11'h060;
        set(msk(0) | msk(6));
        take(6, 1'b1, 2'b10);
        clr(msk(6));
        ret(2'b00);
        take(0, 1'b0, 2'b01);
        set(msk(6));
        take(6, 1'b1, 2'b11);
        set(msk(5));
        none(5);
        clr(msk(6));
        ret(2'b01);
        take(5, 1'b1, 2'b11);
        clr(msk(5) | msk(0));
        ret(2'b01);
        ret(2'b00);
        // global gate and per-source enable
        @(posedge clk);
        gate <= 1'b0;
        set(msk(2));
        none(6);
        @(posedge clk);
        gate <= 1'b1;
        take(2, 1'b0, 2'b01);
        clr(msk(2));
        ret(2'b00);
        @(posedge clk);
        en <= 11'h7ef;
        set(msk(4));
        none(6);
        clr(msk(4));
        // watchdog: gate closed, then zero timeout, then reset instead of interrupt
        @(posedge clk);
        gate <= 1'b0;
        set(msk(1));
        take(1, 1'b1, 2'b10);
        clr(msk(1));
        ret(2'b00);
        @(posedge clk);
        wto <= tlic_pkg::WDT_TIMEOUT_ZERO;
        set(msk(1));
        none(6);
        chk(16'(watchdog_reset_req), 16'h0000, "reset request with interrupt select");
        @(posedge clk);
        wto <= 4'h3;
        wsel <= 1'b0;
        none(3);
        chk(16'(watchdog_reset_req), 16'h0001, "no reset request");
        close_out();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("wrong value at %0t: run timed out", $time);
        close_out();
    end
endmodule // tlic_ctrl_tb
`default_nettype wire
